//--- src/ipf_fetch_stage.sv
// Instruction prefetch stage: OBI read master, alignment buffer, decode hand-off, APB control.
// Assumes an in-order OBI memory and one core clock for the APB, the fetch bus and decode.
//
// Functional notes
// - One instruction per cycle at full bus rate
// - Word fetches only, into three-entry buffer
// - Never more than three words prefetched ahead
// - Request held high until grant seen
// - Address and attributes held until grant
// - Memory-type attributes sent with every request
// - Error response marks the word erroneous
// - Straddling instruction uses two word fetches
// - Program counter bit zero is ignored
// - Read-only bus, no write-side signals
// - At most two granted requests outstanding
// - Cacheable bit follows cacheable region match
// - Bufferable bit always low for fetches
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
module ipf_fetch_stage (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Control transfer
	input wire logic flush_valid,
	input wire logic [31:0] flush_addr,
	// Decode stage
	output logic dec_valid,
	input wire logic dec_ready,
	output ipf_pkg::ipf_dec_t dec_out,
	// OBI instruction bus, read only
	output logic instr_req,
	input wire logic instr_gnt,
	output ipf_pkg::ipf_obi_a_t instr_a,
	input wire logic instr_rvalid,
	input ipf_pkg::ipf_obi_r_t instr_r
);
	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [1:0] ctrl_reg, ctrl_next, mask_reg, mask_next, status_reg, status_next;
	logic [31:0] clo_reg, clo_next, chi_reg, chi_next, prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
	ipf_pkg::ipf_req_state_t rq_reg, rq_next;
	logic req_reg, req_next;
	ipf_pkg::ipf_obi_a_t a_reg, a_next;
	logic [31:0] nf_reg, nf_next, pc_reg, pc_next;
	logic [1:0] outst_reg, outst_next, drop_reg, drop_next;
	logic dec_valid_reg, dec_valid_next;
	ipf_pkg::ipf_dec_t dec_reg, dec_next;

	logic setup, wr, accepted, push, drop_rv, can_issue, issue, pop, out_free, dbg_mode;
	logic lo_c, hi_c;
	logic [1:0] live_next, fifo_next, buf_cnt, ev;
	logic [31:0] issue_addr, target;
	ipf_pkg::ipf_obi_r_t h0, h1;

	function automatic logic is_cacheable(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		return (a >= lo) && (a < hi);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Alignment buffer
	ipf_align_buf u_buf (
		.clk(pclk),
		.rst_n(presetn),
		.flush(flush_valid),
		.push(push),
		.push_word(instr_r),
		.pop(pop),
		.head(h0),
		.second(h1),
		.count(buf_cnt)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Fetch request side
	always_comb begin
		dbg_mode = ctrl_reg[ipf_pkg::CTRL_DBG_BIT];
		target = {flush_addr[31:2], 2'h0};
		accepted = req_reg & instr_gnt;
		push = instr_rvalid & (drop_reg == 2'h0) & ~flush_valid;
		drop_rv = instr_rvalid & ~push;
		outst_next = 2'(outst_reg + {1'b0, accepted} - {1'b0, instr_rvalid});
		if (flush_valid) begin
			drop_next = outst_next;
		end else begin
			drop_next = 2'(drop_reg - {1'b0, drop_rv} + {1'b0, accepted & (rq_reg == ipf_pkg::RQ_STALE)});
		end
		live_next = flush_valid ? 2'h0 : 2'(outst_next - drop_next);
		fifo_next = flush_valid ? 2'h0 : 2'(buf_cnt + {1'b0, push} - {1'b0, pop});
		can_issue = ctrl_reg[ipf_pkg::CTRL_EN_BIT] & (outst_next < 2'(ipf_pkg::MAX_OUTST))
			& ((3'(live_next) + 3'(fifo_next)) < 3'(ipf_pkg::BUF_DEPTH));
		issue_addr = flush_valid ? target : nf_reg;
		rq_next = rq_reg;
		req_next = req_reg;
		a_next = a_reg;
		nf_next = flush_valid ? target : nf_reg;
		issue = 1'b0;
		unique case (rq_reg)
			ipf_pkg::RQ_IDLE: begin
				issue = can_issue;
			end
			ipf_pkg::RQ_LIVE: begin
				if (accepted) begin
					issue = can_issue;
				end else if (flush_valid) begin
					rq_next = ipf_pkg::RQ_STALE;
				end
			end
			ipf_pkg::RQ_STALE: begin
				if (accepted) begin
					issue = can_issue;
				end
			end
			default: begin
				rq_next = ipf_pkg::RQ_IDLE;
			end
		endcase
		if (accepted && !issue) begin
			rq_next = ipf_pkg::RQ_IDLE;
			req_next = 1'b0;
		end
		if (issue) begin
			rq_next = ipf_pkg::RQ_LIVE;
			req_next = 1'b1;
			a_next.addr = issue_addr;
			a_next.memtype = {is_cacheable(issue_addr, clo_reg, chi_reg), 1'b0};
			a_next.prot = ipf_pkg::PROT_FETCH;
			a_next.dbg = dbg_mode;
			nf_next = 32'(issue_addr + 32'h00000004);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rq_reg <= ipf_pkg::RQ_IDLE;
			req_reg <= 1'b0;
			a_reg <= '{addr: ipf_pkg::BOOT_ADDR, memtype: 2'h0, prot: ipf_pkg::PROT_FETCH, dbg: 1'b0};
			nf_reg <= ipf_pkg::BOOT_ADDR;
			outst_reg <= 2'h0;
			drop_reg <= 2'h0;
		end else begin
			rq_reg <= rq_next;
			req_reg <= req_next;
			a_reg <= a_next;
			nf_reg <= nf_next;
			outst_reg <= outst_next;
			drop_reg <= drop_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Aligner towards decode
	always_comb begin
		out_free = ~dec_valid_reg | dec_ready;
		lo_c = h0.rdata[1:0] != 2'h3;
		hi_c = h0.rdata[17:16] != 2'h3;
		pop = 1'b0;
		pc_next = pc_reg;
		dec_valid_next = dec_valid_reg & ~dec_ready;
		dec_next = dec_reg;
		if (flush_valid) begin
			dec_valid_next = 1'b0;
			pc_next = {flush_addr[31:1], 1'b0};
		end else if (out_free && buf_cnt != 2'h0) begin
			dec_next.pc = pc_reg;
			dec_next.err = h0.err;
			if (!pc_reg[1]) begin
				dec_valid_next = 1'b1;
				dec_next.compressed = lo_c;
				dec_next.instr = lo_c ? {16'h0000, h0.rdata[15:0]} : h0.rdata;
				pop = ~lo_c;
				pc_next = 32'(pc_reg + (lo_c ? 32'h00000002 : 32'h00000004));
			end else if (hi_c) begin
				dec_valid_next = 1'b1;
				dec_next.compressed = 1'b1;
				dec_next.instr = {16'h0000, h0.rdata[31:16]};
				pop = 1'b1;
				pc_next = 32'(pc_reg + 32'h00000002);
			end else if (buf_cnt >= 2'h2) begin
				dec_valid_next = 1'b1;
				dec_next.compressed = 1'b0;
				dec_next.instr = {h1.rdata[15:0], h0.rdata[31:16]};
				dec_next.err = h0.err | h1.err;
				pop = 1'b1;
				pc_next = 32'(pc_reg + 32'h00000004);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= ipf_pkg::BOOT_ADDR;
			dec_valid_reg <= 1'b0;
			dec_reg <= '0;
		end else begin
			pc_reg <= pc_next;
			dec_valid_reg <= dec_valid_next;
			dec_reg <= dec_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB registers and interrupt
	always_comb begin
		setup = psel & ~penable;
		wr = psel & penable & pwrite & pready_reg;
		ev = '0;
		ev[ipf_pkg::EV_ERR_BIT] = push & instr_r.err;
		ev[ipf_pkg::EV_DROP_BIT] = drop_rv;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		clo_next = clo_reg;
		chi_next = chi_reg;
		status_next = status_reg;
		if (wr) begin
			unique case (paddr)
				ipf_pkg::ADDR_CTRL: ctrl_next = pwdata[1:0];
				ipf_pkg::ADDR_MASK: mask_next = pwdata[1:0];
				ipf_pkg::ADDR_CLO: clo_next = pwdata;
				ipf_pkg::ADDR_CHI: chi_next = pwdata;
				ipf_pkg::ADDR_STATUS: status_next = status_reg & ~pwdata[1:0];
				default: ;
			endcase
		end
		status_next = status_next | ev;
		irq_next = |(status_next & mask_next);
		pready_next = setup;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		if (setup) begin
			prdata_next = 32'h00000000;
			unique case (paddr)
				ipf_pkg::ADDR_CTRL: prdata_next = {30'h0, ctrl_reg};
				ipf_pkg::ADDR_STATUS: prdata_next = {30'h0, status_reg};
				ipf_pkg::ADDR_MASK: prdata_next = {30'h0, mask_reg};
				ipf_pkg::ADDR_CLO: prdata_next = clo_reg;
				ipf_pkg::ADDR_CHI: prdata_next = chi_reg;
				ipf_pkg::ADDR_STATE: prdata_next = {26'h0, drop_reg, outst_reg, buf_cnt};
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= ipf_pkg::CTRL_RST;
			mask_reg <= ipf_pkg::MASK_RST;
			status_reg <= ipf_pkg::STATUS_RST;
			clo_reg <= ipf_pkg::CLO_RST;
			chi_reg <= ipf_pkg::CHI_RST;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
			clo_reg <= clo_next;
			chi_reg <= chi_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
		end
	end

	// Only read-side OBI signals exist; write channel is absent by construction
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign dec_valid = dec_valid_reg;
	assign dec_out = dec_reg;
	assign instr_req = req_reg;
	assign instr_a = a_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence req_waiting;
		instr_req && !instr_gnt;
	endsequence

	sequence req_held;
		instr_req && $stable(instr_a);
	endsequence

	req_hold_a: assert property (req_waiting |=> req_held)
		else $error("fetch request dropped or changed before grant");
	addr_align_a: assert property (instr_req |-> instr_a.addr[1:0] == 2'h0)
		else $error("unaligned fetch address");
	outst_max_a: assert property (outst_reg <= 2'h2 && !(outst_reg == 2'h2 && instr_req && instr_gnt && !instr_rvalid))
		else $error("more than two fetches outstanding");
	ahead_max_a: assert property ((3'(outst_reg) + 3'(buf_cnt)) <= (3'(drop_reg) + 3'h3))
		else $error("prefetched too far ahead");
	memtype_bits_a: assert property ($rose(instr_req) && $stable(clo_reg) && $stable(chi_reg)
		|-> instr_a.memtype == {is_cacheable(instr_a.addr, clo_reg, chi_reg), 1'b0})
		else $error("memory type mismatch");
	dbg_bit_a: assert property ($rose(instr_req) |-> instr_a.dbg == $past(dbg_mode))
		else $error("debug bit not taken from debug mode");
	drop_resp_a: assert property (instr_rvalid && (drop_reg != 2'h0 || flush_valid) |-> !push ##1 dec_valid_reg == 1'b0 || !$past(flush_valid))
		else $error("stale response reached the buffer");
	err_flag_a: assert property (push && instr_r.err |=> status_reg[ipf_pkg::EV_ERR_BIT])
		else $error("fetch error not recorded");
	full_rate_a: assert property (dec_valid_reg && dec_ready && buf_cnt >= 2'h2 && !flush_valid |=> dec_valid_reg)
		else $error("decode starved with words buffered");
	pc_lsb_a: assert property (dec_valid_reg |-> dec_out.pc[0] == 1'b0)
		else $error("odd program address delivered");

endmodule // ipf_fetch_stage

//--- shared/ipf_pkg.sv
// Constants, register map and carrier types of the instruction prefetch stage.
// Assumes a single core clock domain shared by the APB slave and the fetch bus.
package ipf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Structure
	localparam int unsigned BUF_DEPTH = 3;
	localparam int unsigned MAX_OUTST = 2;
	localparam logic [31:0] BOOT_ADDR = 32'h00000000;
	localparam logic [2:0] PROT_FETCH = 3'h6;

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_CLO = 8'h0C;
	localparam logic [7:0] ADDR_CHI = 8'h10;
	localparam logic [7:0] ADDR_STATE = 8'h14;

	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_DBG_BIT = 1;
	localparam int unsigned EV_ERR_BIT = 0;
	localparam int unsigned EV_DROP_BIT = 1;

	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [1:0] STATUS_RST = 2'h0;
	localparam logic [31:0] CLO_RST = 32'h00000000;
	localparam logic [31:0] CHI_RST = 32'h00000000;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [31:0] addr;
		logic [1:0] memtype;
		logic [2:0] prot;
		logic dbg;
	} ipf_obi_a_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic err;
	} ipf_obi_r_t;

	typedef struct packed {
		logic [31:0] instr;
		logic [31:0] pc;
		logic err;
		logic compressed;
	} ipf_dec_t;

	typedef enum logic [1:0] {RQ_IDLE, RQ_LIVE, RQ_STALE} ipf_req_state_t;

endpackage

//--- src/ipf_align_buf.sv
// Three-entry alignment buffer of fetched words with error flag.
// Assumes the writer never pushes into a full buffer and never pops an empty one.
`timescale 1ns/100ps
module ipf_align_buf (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write side
	input wire logic flush,
	input wire logic push,
	input ipf_pkg::ipf_obi_r_t push_word,
	// Read side
	input wire logic pop,
	output ipf_pkg::ipf_obi_r_t head,
	output ipf_pkg::ipf_obi_r_t second,
	output logic [1:0] count
);
	ipf_pkg::ipf_obi_r_t ent_reg [0:ipf_pkg::BUF_DEPTH-1];
	ipf_pkg::ipf_obi_r_t ent_next [0:ipf_pkg::BUF_DEPTH-1];
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic [1:0] kept;

	always_comb begin
		kept = 2'(cnt_reg - {1'b0, pop});
		for (int i = 0; i < ipf_pkg::BUF_DEPTH; i++) begin
			ent_next[i] = ent_reg[i];
		end
		if (pop) begin
			for (int i = 0; i < ipf_pkg::BUF_DEPTH - 1; i++) begin
				ent_next[i] = ent_reg[i + 1];
			end
		end
		if (push) begin
			ent_next[kept] = push_word;
		end
		cnt_next = flush ? 2'h0 : 2'(kept + {1'b0, push});
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 2'h0;
			for (int i = 0; i < ipf_pkg::BUF_DEPTH; i++) begin
				ent_reg[i] <= '0;
			end
		end else begin
			cnt_reg <= cnt_next;
			for (int i = 0; i < ipf_pkg::BUF_DEPTH; i++) begin
				ent_reg[i] <= ent_next[i];
			end
		end
	end

	assign head = ent_reg[0];
	assign second = ent_reg[1];
	assign count = cnt_reg;

	buf_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		cnt_reg <= 2'(ipf_pkg::BUF_DEPTH) && !(push && !pop && cnt_reg == 2'(ipf_pkg::BUF_DEPTH)))
		else $error("alignment buffer overflow");

endmodule // ipf_align_buf

//--- tb/ipf_mem_model.sv
// OBI instruction memory model: grants, answers once per grant in order, one word answers with error.
// Assumes one clock; stall choices come from the bench as random bits.
`timescale 1ns/100ps
module ipf_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request side
	input wire logic req,
	output logic gnt,
	input ipf_pkg::ipf_obi_a_t a,
	// Response side
	output logic rvalid,
	output ipf_pkg::ipf_obi_r_t r,
	// Bench control
	input wire logic fast,
	input wire logic [1:0] rnd,
	input wire logic err_en,
	input wire logic [31:0] err_addr
);
	logic [31:0] q[$];
	logic [31:0] ad;

	function automatic logic [31:0] word_at(input logic [31:0] x);
		return {x[17:2] ^ 16'h5A3C, x[17:2] * 16'h2C4B};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Read-only content, so reads past the code have no side effect
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gnt <= 1'b0;
			rvalid <= 1'b0;
			r <= '0;
			q.delete();
		end else begin
			if (req && gnt)
				q.push_back(a.addr);
			if (q.size() > 0 && (fast || rnd[1])) begin
				ad = q.pop_front();
				rvalid <= 1'b1;
				r <= '{rdata: word_at(ad), err: err_en && ad == err_addr};
			end else begin
				rvalid <= 1'b0;
				// Released data is inverted every idle cycle, so the stale word shows again every second cycle
				r <= ~r;
			end
			gnt <= fast || rnd[0];
		end
	end
endmodule // ipf_mem_model

//--- tb/tb.sv
// Bench for the instruction prefetch stage: APB registers, decode stream and fetch bus checks.
// Assumes the package, the design and the memory model are compiled before it.
`timescale 1ns/100ps
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, flush_valid = 1'b0;
	logic dec_ready = 1'b0, fast = 1'b0, fl_on = 1'b0, fl_req = 1'b0, dbg_exp = 1'b0, prev_req = 1'b0, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, flush_addr = 32'h00000000, exp_pc = 32'h00000000, rd;
	logic [1:0] rnd = 2'h0;
	logic pready, pslverr, irq, dec_valid, instr_req, instr_gnt, instr_rvalid, prev_gnt;
	logic [31:0] prdata, prev_addr;
	ipf_pkg::ipf_dec_t dec_out;
	ipf_pkg::ipf_obi_a_t instr_a;
	ipf_pkg::ipf_obi_r_t instr_r;
	int bad_count = 0, n_tests = 0, ntr = 0, nout = 0, age = 0, n0, seed = 32'ha81d;

	ipf_fetch_stage ipf_fetch_stage_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .flush_valid(flush_valid), .flush_addr(flush_addr), .dec_valid(dec_valid),
		.dec_ready(dec_ready), .dec_out(dec_out), .instr_req(instr_req), .instr_gnt(instr_gnt),
		.instr_a(instr_a), .instr_rvalid(instr_rvalid), .instr_r(instr_r));
	ipf_mem_model ipf_mem_model_i (.clk(pclk), .rst_n(presetn), .req(instr_req), .gnt(instr_gnt), .a(instr_a),
		.rvalid(instr_rvalid), .r(instr_r), .fast(fast), .rnd(rnd), .err_en(1'b1), .err_addr(32'h00000020));

	initial begin
		forever #50 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic end_of_test();
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(nm, e, rd);
	endtask

	function automatic logic [15:0] half(input logic [31:0] p);
		logic [31:0] w;
		// Same content as the memory model holds at this word
		w = {p[17:2] ^ 16'h5A3C, p[17:2] * 16'h2C4B};
		return p[1] ? w[31:16] : w[15:0];
	endfunction

	function automatic logic bad_w(input logic [31:0] p);
		return {p[31:2], 2'h0} == 32'h00000020;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Random stalls and flushes; decode never takes in a flush cycle
	always @(posedge pclk) begin : drv
		logic [31:0] x;
		logic f;
		x = $random(seed);
		f = presetn && !flush_valid && ((fl_on && x[9:5] == 5'h00) || (fl_req && instr_req && instr_gnt));
		rnd <= x[1:0];
		dec_ready <= !f && (fast || x[2]);
		flush_valid <= f;
		flush_addr <= fl_req ? 32'h00000100 : {23'h000000, x[24:16]};
		if (f)
			fl_req = 1'b0;
	end

	// Fetch bus and decode stream watcher
	always @(posedge pclk) begin : mon
		logic [15:0] h;
		logic c, e;
		if (presetn) begin
			if (prev_req && !prev_gnt) begin
				chk("req_hold", 1, instr_req);
				chk("addr_hold", prev_addr, instr_a.addr);
			end
			if (instr_req && instr_gnt) begin
				chk("align", 0, instr_a.addr[1:0]);
				chk("memtype", {instr_a.addr >= 32'h00000040 && instr_a.addr < 32'h00000100, 1'b0}, instr_a.memtype);
				chk("prot", ipf_pkg::PROT_FETCH, instr_a.prot);
				if (age > 8)
					chk("dbg", dbg_exp, instr_a.dbg);
			end
			nout = nout + (instr_req && instr_gnt) - instr_rvalid;
			chk("outstanding", 1, nout <= 2);
			if (dec_valid && dec_ready) begin
				h = half(exp_pc);
				c = h[1:0] != 2'h3;
				e = bad_w(exp_pc) || (!c && bad_w(exp_pc + 2));
				chk("pc", exp_pc, dec_out.pc);
				chk("compressed", c, dec_out.compressed);
				chk("err", e, dec_out.err);
				if (!e)
					chk("instr", c ? {16'h0000, h} : {half(exp_pc + 2), h}, dec_out.instr);
				exp_pc = exp_pc + (c ? 2 : 4);
				ntr++;
			end
			if (flush_valid)
				exp_pc = {flush_addr[31:1], 1'b0};
			age++;
		end
		prev_req = instr_req;
		prev_gnt = instr_gnt;
		prev_addr = instr_a.addr;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rchk("reset_val", 8'(4 * i), 32'h00000000);
		rchk("unmapped", 8'h18, 32'h00000000);
		chk("slverr", 1, er);
		apb(1'b1, ipf_pkg::ADDR_STATE, 32'hFFFFFFFF);
		rchk("state_ro", ipf_pkg::ADDR_STATE, 32'h00000000);
		apb(1'b1, ipf_pkg::ADDR_CLO, 32'h00000040);
		apb(1'b1, ipf_pkg::ADDR_CHI, 32'h00000100);
		rchk("clo", ipf_pkg::ADDR_CLO, 32'h00000040);
		apb(1'b1, ipf_pkg::ADDR_CTRL, 32'h00000001);
		age = 0;
		fast <= 1'b1;
		repeat (12) @(negedge pclk);
		n0 = ntr;
		repeat (40) @(negedge pclk);
		chk("rate", n0 + 40, ntr);
		@(posedge pclk);
		fast <= 1'b0;
		fl_on = 1'b1;
		repeat (200) @(posedge pclk);
		apb(1'b1, ipf_pkg::ADDR_CTRL, 32'h00000003);
		dbg_exp = 1'b1;
		age = 0;
		repeat (200) @(posedge pclk);
		fl_on = 1'b0;
		fl_req = 1'b1;
		for (int i = 0; i < 50 && fl_req; i++)
			@(posedge pclk);
		repeat (10) @(posedge pclk);
		rchk("status", ipf_pkg::ADDR_STATUS, 32'h00000003);
		@(negedge pclk);
		chk("irq_masked", 0, irq);
		apb(1'b1, ipf_pkg::ADDR_MASK, 32'h00000001);
		repeat (2) @(negedge pclk);
		chk("irq_on", 1, irq);
		apb(1'b1, ipf_pkg::ADDR_STATUS, 32'h00000001);
		repeat (2) @(negedge pclk);
		chk("irq_off", 0, irq);
		rchk("status_w1c", ipf_pkg::ADDR_STATUS, 32'h00000002);
		apb(1'b1, ipf_pkg::ADDR_STATUS, 32'h00000002);
		rchk("status_clr", ipf_pkg::ADDR_STATUS, 32'h00000000);
		end_of_test();
	end

	initial begin
		repeat (3000) @(posedge pclk);
		bad_count++;
		end_of_test();
	end
endmodule // tb
